// [design/fps_pkg.sv]
package fps_pkg;

  // ==================================================
  // Widths and sizes
  localparam int unsigned SET_NUM = 64;
  localparam int unsigned IDX_W = 6;
  localparam int unsigned LIM_W = 7;
  localparam int unsigned REP_W = 9;
  localparam int unsigned PARAM_W = 32;

  // ==================================================
  // Register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_SET_COUNT = 8'h04;
  localparam logic [7:0] OFS_SET_PTR = 8'h08;
  localparam logic [7:0] OFS_REPEAT = 8'h0c;
  localparam logic [7:0] OFS_CMD = 8'h10;
  localparam logic [7:0] OFS_ACTIVE = 8'h14;
  localparam logic [7:0] OFS_STATUS = 8'h18;

  // ==================================================
  // Field positions
  localparam int unsigned CTRL_ON_BIT = 0;
  localparam int unsigned CTRL_POL_LSB = 1;
  localparam int unsigned CTRL_CHUNK_BIT = 3;
  localparam int unsigned CMD_STORE_BIT = 0;
  localparam int unsigned ST_SET_LSB = 0;
  localparam int unsigned ST_USE_LSB = 8;
  localparam int unsigned ST_RUN_BIT = 20;
  localparam int unsigned ST_DRAIN_BIT = 21;

  // ==================================================
  // Encodings and reset values
  localparam logic [1:0] POLICY_AUTO = 2'h0;
  localparam logic [LIM_W-1:0] LIMIT_MAX = 7'h40;
  localparam logic [LIM_W-1:0] LIMIT_RST = 7'h01;
  localparam logic [REP_W-1:0] REP_MAX = 9'h100;
  localparam logic [REP_W-1:0] REP_RST = 9'h001;
  localparam logic [PARAM_W-1:0] ACTIVE_RST = 32'h0000_0000;
  localparam logic [PARAM_W-1:0] SET_DEFAULT = 32'h0000_0000;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_RUN,
    ST_DRAIN
  } fps_state_t;

endpackage

// [design/fps_sync_edge.sv]
`timescale 1ns/1ps
module fps_sync_edge (
  // Clock and reset
  input wire logic clk_in,
  input wire logic nrst_in,
  // Pin and pulse
  input wire logic pin_in,
  output logic rise_out
);

  // ==================================================
  // Two-stage synchroniser, edge taken after stage two
  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic rise;
  } fps_sync_t;

  fps_sync_t q_r;
  fps_sync_t q_nxt;

  always_comb begin
    q_nxt = q_r;
    q_nxt.s1 = pin_in;
    q_nxt.s2 = q_r.s1;
    q_nxt.s3 = q_r.s2;
    q_nxt.rise = q_r.s2 & ~q_r.s3;
  end

  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      q_r <= '0;
    end else begin
      q_r <= q_nxt;
    end
  end

  assign rise_out = q_r.rise;

endmodule

// [design/fps_sequencer.sv]
// Chosen here: the Wishbone slave port and the register offsets.
`timescale 1ns/1ps
// What this block does
// - On enable in automatic policy, set 0 parameters are copied into the active parameter set.
// - First frame trigger after enabling acquires with set 0.
// - Later triggers reuse the current set until its use count reaches its repeat count.
// - After the repeat count is used up, the next trigger loads the next set.
// - After the last set below the set count limit, the cycle wraps to set 0.
// - In automatic policy only frame triggers advance sets, no software step.
// - Disabling during a frame lets that frame finish, then cycling stops.
// - Disabling restores the active parameters held just before enabling.
// - The set count limit accepts values up to 64.
// - The set pointer accepts indices 0 through 63.
// - Each set's repeat count accepts 1 through 256.
// - The store command copies active parameters into the set chosen by the pointer.
// - Sets in range never stored supply default parameters when used.
// - With index chunks on, each frame carries the index of its set.
module fps_sequencer (
  // Clock and reset
  input wire logic MCLK_IN,
  input wire logic NRST_IN,
  // Wishbone slave
  input wire logic WB_CYC_IN,
  input wire logic WB_STB_IN,
  input wire logic WB_WE_IN,
  input wire logic [7:0] WB_ADR_IN,
  input wire logic [3:0] WB_SEL_IN,
  input wire logic [31:0] WB_DAT_IN,
  // Wishbone answer
  output logic [31:0] WB_DAT_OUT,
  output logic WB_ACK_OUT,
  // Frame side
  input wire logic FRAME_TRIG_IN,
  input wire logic FRAME_BUSY_IN,
  // Active parameters
  output logic [31:0] ACTIVE_PARAM_OUT,
  output logic [5:0] CUR_SET_OUT,
  output logic SEQ_RUNNING_OUT,
  // Frame tags
  output logic [5:0] FRAME_SET_OUT,
  output logic FRAME_SET_VALID_OUT
);

  localparam int unsigned IW = fps_pkg::IDX_W;
  localparam int unsigned PW = fps_pkg::PARAM_W;

  // ==================================================
  // State
  typedef struct packed {
    // Control
    fps_pkg::fps_state_t state;
    logic on;
    logic [1:0] policy;
    logic chunk_en;
    logic [fps_pkg::LIM_W-1:0] limit;
    logic [IW-1:0] ptr;
    logic [fps_pkg::REP_W-1:0] rep_stage;

    // Sequencing
    logic [PW-1:0] active;
    logic [PW-1:0] backup;
    logic [IW-1:0] cur;
    logic [fps_pkg::REP_W-1:0] use_cnt;
    logic first;
    logic run;

    // Set storage, cleared by reset only
    logic [fps_pkg::SET_NUM-1:0][PW-1:0] pmem;
    logic [fps_pkg::SET_NUM-1:0][7:0] rmem;
    logic [fps_pkg::SET_NUM-1:0] stored;

    // Bus answer and frame tag
    logic ack;
    logic [31:0] rdat;
    logic [IW-1:0] fset;
    logic fvalid;
  } fps_regs_t;

  fps_regs_t q_r;
  fps_regs_t q_nxt;
  logic trig_rise;

  // ==================================================
  // Trigger pin is asynchronous, so it is synchronised first
  fps_sync_edge u_trig (
    .clk_in(MCLK_IN),
    .nrst_in(NRST_IN),
    .pin_in(FRAME_TRIG_IN),
    .rise_out(trig_rise)
  );

  // ==================================================
  // Set lookup; unstored sets fall back to defaults
  function automatic logic [PW-1:0] set_param(input fps_regs_t s, input logic [IW-1:0] idx);
    if (s.stored[idx]) begin
      set_param = s.pmem[idx];
    end else begin
      set_param = fps_pkg::SET_DEFAULT;
    end
  endfunction

  function automatic logic [fps_pkg::REP_W-1:0] set_reps(input fps_regs_t s, input logic [IW-1:0] idx);
    // Stored minus one so that 256 fits eight bits
    if (s.stored[idx]) begin
      set_reps = {1'b0, s.rmem[idx]} + 9'h001;
    end else begin
      set_reps = fps_pkg::REP_RST;
    end
  endfunction

  function automatic logic [31:0] merge_bytes(input logic [31:0] old, input logic [31:0] wd, input logic [3:0] sel);
    merge_bytes = old;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        merge_bytes[b*8 +: 8] = wd[b*8 +: 8];
      end
    end
  endfunction

  // ==================================================
  // Next state
  logic req;
  logic wr;
  logic [31:0] wdat;
  logic [31:0] rd;
  logic [IW-1:0] last_idx;
  logic [IW-1:0] next_idx;
  logic [fps_pkg::LIM_W-1:0] lim_in;
  logic [fps_pkg::REP_W-1:0] rep_in;

  always_comb begin
    q_nxt = q_r;
    req = WB_CYC_IN & WB_STB_IN & ~q_r.ack;
    wr = req & WB_WE_IN;
    wdat = 32'h0000_0000;
    rd = 32'h0000_0000;
    lim_in = '0;
    rep_in = '0;
    last_idx = IW'(q_r.limit - 7'h01);
    if (q_r.cur >= last_idx) begin
      next_idx = '0;
    end else begin
      next_idx = IW'(q_r.cur + 6'h01);
    end
    // Ack blocks a second take while a held strobe waits for release
    q_nxt.ack = req;
    q_nxt.fvalid = 1'b0;

    // ==================================================
    // Register reads
    case (WB_ADR_IN)
      fps_pkg::OFS_CTRL: begin
        rd[fps_pkg::CTRL_ON_BIT] = q_r.on;
        rd[fps_pkg::CTRL_POL_LSB +: 2] = q_r.policy;
        rd[fps_pkg::CTRL_CHUNK_BIT] = q_r.chunk_en;
      end

      fps_pkg::OFS_SET_COUNT: begin
        rd[fps_pkg::LIM_W-1:0] = q_r.limit;
      end

      fps_pkg::OFS_SET_PTR: begin
        rd[IW-1:0] = q_r.ptr;
      end

      fps_pkg::OFS_REPEAT: begin
        rd[fps_pkg::REP_W-1:0] = q_r.rep_stage;
      end

      fps_pkg::OFS_CMD: begin
        // Command is write-only, a read sees zero
        rd = 32'h0000_0000;
      end

      fps_pkg::OFS_ACTIVE: begin
        rd = q_r.active;
      end

      fps_pkg::OFS_STATUS: begin
        rd[fps_pkg::ST_SET_LSB +: IW] = q_r.cur;
        rd[fps_pkg::ST_USE_LSB +: fps_pkg::REP_W] = q_r.use_cnt;
        rd[fps_pkg::ST_RUN_BIT] = (q_r.state == fps_pkg::ST_RUN);
        rd[fps_pkg::ST_DRAIN_BIT] = (q_r.state == fps_pkg::ST_DRAIN);
      end

      default: begin
        rd = 32'h0000_0000;
      end
    endcase
    q_nxt.rdat = req ? rd : 32'h0000_0000;

    // ==================================================
    // Register writes; unmapped offsets are acknowledged and dropped
    if (wr) begin
      case (WB_ADR_IN)
        fps_pkg::OFS_CTRL: begin
          wdat = merge_bytes({28'h0, q_r.chunk_en, q_r.policy, q_r.on}, WB_DAT_IN, WB_SEL_IN);
          q_nxt.on = wdat[fps_pkg::CTRL_ON_BIT];
          // Chunk bit may change at any time; it only tags frames
          q_nxt.chunk_en = wdat[fps_pkg::CTRL_CHUNK_BIT];
          // Policy only changes while stopped, so a running cycle is never re-steered
          if (q_r.state == fps_pkg::ST_IDLE) begin
            q_nxt.policy = wdat[fps_pkg::CTRL_POL_LSB +: 2];
          end
        end

        fps_pkg::OFS_SET_COUNT: begin
          wdat = merge_bytes({25'h0, q_r.limit}, WB_DAT_IN, WB_SEL_IN);
          lim_in = wdat[fps_pkg::LIM_W-1:0];
          if (q_r.state == fps_pkg::ST_IDLE) begin
            // Clamped into 1..64
            if (wdat[31:7] != '0 || lim_in > fps_pkg::LIMIT_MAX) begin
              q_nxt.limit = fps_pkg::LIMIT_MAX;
            end else if (lim_in == '0) begin
              q_nxt.limit = fps_pkg::LIMIT_RST;
            end else begin
              q_nxt.limit = lim_in;
            end
          end
        end

        fps_pkg::OFS_SET_PTR: begin
          wdat = merge_bytes({26'h0, q_r.ptr}, WB_DAT_IN, WB_SEL_IN);
          q_nxt.ptr = wdat[IW-1:0];
        end

        fps_pkg::OFS_REPEAT: begin
          wdat = merge_bytes({23'h0, q_r.rep_stage}, WB_DAT_IN, WB_SEL_IN);
          rep_in = wdat[fps_pkg::REP_W-1:0];
          // Clamped into 1..256
          if (wdat[31:9] != '0 || rep_in > fps_pkg::REP_MAX) begin
            q_nxt.rep_stage = fps_pkg::REP_MAX;
          end else if (rep_in == '0) begin
            q_nxt.rep_stage = fps_pkg::REP_RST;
          end else begin
            q_nxt.rep_stage = rep_in;
          end
        end

        fps_pkg::OFS_CMD: begin
          // Store is refused while sequencing, as it would race the active set
          if (WB_SEL_IN[0] && WB_DAT_IN[fps_pkg::CMD_STORE_BIT] && q_r.state == fps_pkg::ST_IDLE) begin
            q_nxt.pmem[q_r.ptr] = q_r.active;
            q_nxt.rmem[q_r.ptr] = 8'(q_r.rep_stage - 9'h001);
            q_nxt.stored[q_r.ptr] = 1'b1;
          end
        end

        fps_pkg::OFS_ACTIVE: begin
          if (q_r.state == fps_pkg::ST_IDLE) begin
            q_nxt.active = merge_bytes(q_r.active, WB_DAT_IN, WB_SEL_IN);
          end
        end

        default: begin
        end
      endcase
    end

    // ==================================================
    // Sequencing
    case (q_r.state)
      fps_pkg::ST_IDLE: begin
        if (q_r.on && q_r.policy == fps_pkg::POLICY_AUTO) begin
          q_nxt.backup = q_r.active;
          q_nxt.active = set_param(q_r, '0);
          q_nxt.cur = '0;
          q_nxt.use_cnt = '0;
          q_nxt.first = 1'b1;
          q_nxt.state = fps_pkg::ST_RUN;
        end
      end

      fps_pkg::ST_RUN: begin
        // A trigger in the disable cycle is dropped: disable wins
        if (!q_r.on) begin
          q_nxt.state = fps_pkg::ST_DRAIN;
        end else if (trig_rise) begin
          q_nxt.fset = q_r.cur;
          q_nxt.first = 1'b0;
          if (q_r.first) begin
            q_nxt.use_cnt = 9'h001;
          end else if (q_r.use_cnt < set_reps(q_r, q_r.cur)) begin
            q_nxt.use_cnt = q_r.use_cnt + 9'h001;
          end else begin
            q_nxt.cur = next_idx;
            q_nxt.fset = next_idx;
            q_nxt.active = set_param(q_r, next_idx);
            q_nxt.use_cnt = 9'h001;
          end
          q_nxt.fvalid = q_r.chunk_en;
        end
      end

      fps_pkg::ST_DRAIN: begin
        // Frame in flight keeps its set; restore once it is out
        if (!FRAME_BUSY_IN) begin
          q_nxt.active = q_r.backup;
          q_nxt.use_cnt = '0;
          q_nxt.state = fps_pkg::ST_IDLE;
        end
      end

      default: begin
        q_nxt.state = fps_pkg::ST_IDLE;
      end
    endcase

    // Running flag registered so the output needs no decode
    q_nxt.run = (q_nxt.state == fps_pkg::ST_RUN);
  end

  // ==================================================
  // Registers; stored sets are volatile and clear on reset
  always_ff @(posedge MCLK_IN) begin
    if (!NRST_IN) begin
      q_r <= '0;
      q_r.state <= fps_pkg::ST_IDLE;
      q_r.limit <= fps_pkg::LIMIT_RST;
      q_r.rep_stage <= fps_pkg::REP_RST;
      q_r.active <= fps_pkg::ACTIVE_RST;
    end else begin
      q_r <= q_nxt;
    end
  end

  // ==================================================
  // Outputs
  assign WB_ACK_OUT = q_r.ack;
  assign WB_DAT_OUT = q_r.rdat;
  assign ACTIVE_PARAM_OUT = q_r.active;
  assign CUR_SET_OUT = q_r.cur;
  assign SEQ_RUNNING_OUT = q_r.run;
  assign FRAME_SET_OUT = q_r.fset;
  assign FRAME_SET_VALID_OUT = q_r.fvalid;

endmodule

// [test/fps_trig_src.sv]
`timescale 1ns/1ps
// ==========
// Trigger source and frame busy
module fps_trig_src (
  // Clock
  input wire logic clk_in,
  // Control
  input wire logic fire_in,
  input wire logic hold_in,
  // Pins
  output logic trig_out,
  output logic busy_out
);
  logic [3:0] cnt_r = 4'h0;
  always @(posedge clk_in) begin
    if (fire_in)
      cnt_r <= 4'hc;
    else if (cnt_r != 4'h0)
      cnt_r <= cnt_r - 4'h1;
  end
  // Pin high 3 cycles, then low long before the next rise
  assign trig_out = cnt_r > 4'h9;
  // Hold stretches a frame so a disable lands mid-frame
  assign busy_out = hold_in || (cnt_r != 4'h0);
endmodule

// [test/fps_sequencer_assertions.sv]
`timescale 1ns/1ps
// ==========
// Port checker
module fps_sequencer_assertions (
  // Clock and reset
  input wire logic MCLK_IN,
  input wire logic NRST_IN,
  // Bus
  input wire logic WB_CYC_IN,
  input wire logic WB_STB_IN,
  input wire logic [31:0] WB_DAT_OUT,
  input wire logic WB_ACK_OUT,
  // Frame side
  input wire logic [31:0] ACTIVE_PARAM_OUT,
  input wire logic [5:0] CUR_SET_OUT,
  input wire logic SEQ_RUNNING_OUT,
  input wire logic [5:0] FRAME_SET_OUT,
  input wire logic FRAME_SET_VALID_OUT
);
  default clocking cb @(posedge MCLK_IN); endclocking
  default disable iff (!NRST_IN);
  ack_pulse_a: assert property (WB_ACK_OUT |=> !WB_ACK_OUT)
    else $error("ack held");
  ack_answer_a: assert property (WB_CYC_IN && WB_STB_IN && !WB_ACK_OUT |=> WB_ACK_OUT)
    else $error("no ack");
  dat_idle_a: assert property (!WB_ACK_OUT |-> WB_DAT_OUT == 32'h0)
    else $error("data outside ack");
  tag_pulse_a: assert property (FRAME_SET_VALID_OUT |=> !FRAME_SET_VALID_OUT)
    else $error("tag held");
  tag_run_a: assert property (FRAME_SET_VALID_OUT |-> $past(SEQ_RUNNING_OUT))
    else $error("tag while stopped");
  tag_set_a: assert property (FRAME_SET_VALID_OUT |-> FRAME_SET_OUT == CUR_SET_OUT)
    else $error("tag index wrong");
  start_set_a: assert property ($rose(SEQ_RUNNING_OUT) |-> CUR_SET_OUT == 6'h0)
    else $error("start not at set 0");
  set_step_a: assert property (SEQ_RUNNING_OUT && $past(SEQ_RUNNING_OUT) && $changed(CUR_SET_OUT)
    |-> CUR_SET_OUT == $past(CUR_SET_OUT) + 6'h1 || CUR_SET_OUT == 6'h0)
    else $error("set skipped");
  cover property ($rose(SEQ_RUNNING_OUT));
  cover property ($fell(SEQ_RUNNING_OUT));
  cover property (FRAME_SET_VALID_OUT && CUR_SET_OUT == 6'h0 && $past(CUR_SET_OUT) != 6'h0);
endmodule

// [test/fps_sequencer_tb.sv]
`timescale 1ns/1ps
// ==========
// Bench top
module fps_sequencer_tb;
  logic clk = 1'b0, nrst = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0, fire = 1'b0, hold = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [3:0] sel = 4'h0;
  logic [31:0] wdat = 32'h0, rdat, act, a0, p [6];
  logic ack, run, vld, trig, busy;
  logic [5:0] cur, fset;
  logic [8:0] rep [6];
  logic [37:0] fq [$];
  logic [31:0] rq [$];
  int bad_count = 0, n_checks = 0, seed = 32'h345d, c, u;
  initial forever #10 clk = ~clk;
  fps_sequencer dut_u (.MCLK_IN(clk), .NRST_IN(nrst), .WB_CYC_IN(cyc), .WB_STB_IN(stb),
    .WB_WE_IN(we), .WB_ADR_IN(adr), .WB_SEL_IN(sel), .WB_DAT_IN(wdat), .WB_DAT_OUT(rdat),
    .WB_ACK_OUT(ack), .FRAME_TRIG_IN(trig), .FRAME_BUSY_IN(busy), .ACTIVE_PARAM_OUT(act),
    .CUR_SET_OUT(cur), .SEQ_RUNNING_OUT(run), .FRAME_SET_OUT(fset), .FRAME_SET_VALID_OUT(vld));
  fps_trig_src src_u (.clk_in(clk), .fire_in(fire), .hold_in(hold), .trig_out(trig), .busy_out(busy));
  // ==========
  // Tasks
  task automatic chk(input string nm, input logic [37:0] seen, input logic [37:0] exp);
    n_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("FAIL %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic finish_test;
    if (bad_count == 0 && n_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge clk);
    {cyc, stb, we, adr, sel, wdat} <= {2'b11, w, a, 4'hf, d};
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (ack !== 1'b1 && k < 20);
    if (k >= 20) begin
      bad_count++;
      finish_test();
    end
    {cyc, stb} <= 2'b00;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    rq.push_back(e);
    wb(1'b0, a, 32'h0);
  endtask
  // Model steps the set before the pulse so the note is queued first
  task automatic shot(input logic exp);
    if (exp) begin
      if (u < rep[c])
        u++;
      else begin
        c = (c + 1) % 6;
        u = 1;
      end
      fq.push_back({c[5:0], p[c]});
    end
    @(posedge clk);
    fire <= 1'b1;
    @(posedge clk);
    fire <= 1'b0;
    repeat (16) @(posedge clk);
  endtask
  // ==========
  // Result watcher
  always @(posedge clk) begin
    if (ack === 1'b1 && we === 1'b0)
      chk("read", rdat, rq.pop_front());
    if (vld === 1'b1 && fq.size() == 0)
      chk("extra frame", 38'h1, 38'h0);
    else if (vld === 1'b1)
      chk("frame", {fset, act}, fq.pop_front());
  end
  // ==========
  // Main sequence
  initial begin
    repeat (16) @(posedge clk);
    nrst <= 1'b1;
    rd(fps_pkg::OFS_SET_COUNT, 32'h1);
    rd(fps_pkg::OFS_REPEAT, 32'h1);
    rd(8'h1c, 32'h0);
    wb(1'b1, fps_pkg::OFS_SET_COUNT, 32'h50);
    rd(fps_pkg::OFS_SET_COUNT, 32'h40);
    wb(1'b1, fps_pkg::OFS_REPEAT, 32'h1ff);
    rd(fps_pkg::OFS_REPEAT, 32'h100);
    wb(1'b1, fps_pkg::OFS_SET_PTR, 32'h3f);
    rd(fps_pkg::OFS_SET_PTR, 32'h3f);
    wb(1'b1, fps_pkg::OFS_SET_COUNT, 32'h6);
    for (int i = 0; i < 6; i++) begin
      p[i] = (i == 3) ? fps_pkg::SET_DEFAULT : $random(seed);
      rep[i] = (i == 1) ? 9'h3 : (i == 5) ? 9'h2 : fps_pkg::REP_RST;
      // Set 3 is left unstored on purpose
      if (i != 3) begin
        wb(1'b1, fps_pkg::OFS_SET_PTR, i);
        wb(1'b1, fps_pkg::OFS_ACTIVE, p[i]);
        wb(1'b1, fps_pkg::OFS_REPEAT, rep[i]);
        wb(1'b1, fps_pkg::OFS_CMD, 32'h1);
      end
    end
    a0 = $random(seed);
    wb(1'b1, fps_pkg::OFS_ACTIVE, a0);
    c = 0;
    u = 0;
    wb(1'b1, fps_pkg::OFS_CTRL, 32'h9);
    repeat (2) @(posedge clk);
    chk("enable", {run, cur, act}, {1'b1, 6'h0, p[0]});
    for (int k = 0; k < 11; k++)
      shot(1'b1);
    hold <= 1'b1;
    shot(1'b1);
    wb(1'b1, fps_pkg::OFS_CTRL, 32'h8);
    repeat (3) @(posedge clk);
    chk("drain", {run, act}, {1'b0, p[c]});
    shot(1'b0);
    hold <= 1'b0;
    repeat (3) @(posedge clk);
    chk("restore", act, a0);
    wb(1'b1, fps_pkg::OFS_CTRL, 32'h3);
    repeat (3) @(posedge clk);
    chk("policy", run, 1'b0);
    shot(1'b0);
    wb(1'b1, fps_pkg::OFS_CTRL, 32'h1);
    shot(1'b0);
    rd(fps_pkg::OFS_STATUS, 32'h0010_0100);
    shot(1'b0);
    rd(fps_pkg::OFS_STATUS, 32'h0010_0101);
    wb(1'b1, fps_pkg::OFS_CTRL, 32'h0);
    chk("frames left", fq.size(), 38'h0);
    finish_test();
  end
endmodule
bind fps_sequencer fps_sequencer_assertions chk_u (.MCLK_IN, .NRST_IN, .WB_CYC_IN, .WB_STB_IN,
  .WB_DAT_OUT, .WB_ACK_OUT, .ACTIVE_PARAM_OUT, .CUR_SET_OUT, .SEQ_RUNNING_OUT, .FRAME_SET_OUT,
  .FRAME_SET_VALID_OUT);
